/* src/crtc_vtiming.v */
// vertical timing, cursor, light pen and display memory addressing
// of a crt controller; ref_clk is the character clock, so every
// edge is one character time. line timing (line end, horizontal
// display and blank) comes from the horizontal block on ref_clk.
// processor bus and light pen pins are asynchronous to ref_clk.
//
// Overview of operation
// R1: five-bit vertical adjust adds lines after rows
// R2: seven-bit displayed rows gate display enable
// R3: seven-bit row where vertical sync begins
// R4: scan lines per row minus one, wrap
// R5: cursor first and last scan lines held
// R6: cursor modes steady, off, fast, slow blink
// R7: start address loads, advances per character
// R8: cursor when address matches and scan inside
// R9: mode bit five delays cursor one character
// R10: light pen edge captures display address
// R11: update address kept for transparent access
// R12: each update access increments update address
// R13: index 31 stores nothing, triggers update
// R14: mode bit two selects row/column addressing
// R15: shared memory arbitration is done outside
// R16: external logic muxes addresses by phase
// R17: blanking scheme host waits for retrace
// R18: update address driven during second phase
// R19: blanking mode updates only during blanking
// R20: outside latches hold data until retrace
// R21: index written with select low, else data
// R22: top row-scan line acts as update strobe
// R23: unused bits zero, index 31 undriven
// R24: update wraps, frame start reloads address
`include "crtc_defs.vh"
module crtc_vtiming (
    input wire ref_clk, // character clock
    input wire rst, // synchronous reset, high
    input wire chip_select_n, // bus chip select pin, low
    input wire register_select, // bus register select pin
    input wire read_write, // bus direction pin, high read
    input wire bus_enable, // bus phase enable pin
    input wire [7:0] data_in, // bus data pins, input side
    output reg [7:0] data_out, // bus data pins, output side
    output reg data_oe_n, // low while data pins driven
    input wire light_pen_input, // light pen strobe pin
    input wire line_end, // pulse at last char of a line
    input wire h_display, // horizontal display window
    input wire h_blank, // horizontal blanking
    input wire [6:0] vert_total, // character rows minus one
    input wire [3:0] vsync_width, // vsync width in lines
    output reg [13:0] memory_address_lines, // display memory addr
    output reg [4:0] row_scan_lines, // scan line within row
    output reg display_enable, // active display
    output reg cursor, // cursor video
    output reg vsync // vertical sync
);
    localparam PH_ROWS = 1'b0;
    localparam PH_ADJ = 1'b1;
    // programmed registers
    reg [4:0] idx;
    reg [4:0] vert_total_adjust;
    reg [6:0] vert_displayed_rows;
    reg [6:0] vert_sync_row;
    reg [7:0] mode_control;
    reg [4:0] scan_lines_per_row;
    reg [6:0] cursor_start_line;
    reg [4:0] cursor_end_line;
    reg [13:0] start_addr;
    reg [13:0] cursor_addr;
    reg [13:0] light_pen_addr;
    reg [13:0] update_addr;
    reg upd_ready;
    reg pen_full;
    // pin synchronisers: stage one feeds stage two only
    reg [4:0] pin_s1;
    reg [4:0] pin_s2;
    reg [7:0] din_s1;
    reg [7:0] din_s2;
    reg e_d;
    reg pen_d;
    // timing state
    reg phase;
    reg [6:0] row_cnt;
    reg [4:0] scan_cnt;
    reg [4:0] adj_cnt;
    reg [4:0] vs_cnt;
    reg [4:0] field_cnt;
    reg [13:0] disp_addr;
    reg [13:0] row_base;
    reg cur_hold;
    reg de_hold;
    reg upd_pend;
    wire cs_s = pin_s2[4];
    wire sel_s = pin_s2[3];
    wire rw_s = pin_s2[2];
    wire e_s = pin_s2[1];
    wire pen_s = pin_s2[0];
    // a bus access completes at the falling edge of the phase enable
    wire e_fall = e_d & ~e_s;
    wire acc = e_fall & ~cs_s & sel_s;
    wire wr_idx = e_fall & ~cs_s & ~sel_s & ~rw_s; // R21
    wire wr = acc & ~rw_s;
    wire rd = acc & rw_s;
    wire trig = acc & (idx == `CRTC_IDX_TRIG); // R13
    wire rc_mode = mode_control[`CRTC_MODE_RC];
    wire trans = mode_control[`CRTC_MODE_TRANS];
    wire tblank = mode_control[`CRTC_MODE_TBLANK];
    wire [1:0] cmode = cursor_start_line[`CRTC_CMODE_HI:`CRTC_CMODE_LO];
    // vertical counters
    wire row_end = (scan_cnt == scan_lines_per_row); // R4
    wire last_row = (row_cnt == vert_total);
    wire adj_done = (adj_cnt == vert_total_adjust);
    wire v_active = (phase == PH_ROWS) &
        (row_cnt < vert_displayed_rows); // R2
    wire v_blank = ~v_active;

    // frame restarts after the last row, or after the adjust lines;
    // a zero adjust skips the adjust phase altogether
    wire frame_end = line_end & ((phase == PH_ROWS) ?
        (row_end & last_row & (vert_total_adjust == 5'h00)) : adj_done);

    // next row base and column step, in binary or row/column form
    wire [13:0] next_row_base = rc_mode ?
        {row_base[13:8] + 6'h01, start_addr[7:0]} : disp_addr; // R14
    wire [13:0] next_char = rc_mode ?
        {disp_addr[13:8], disp_addr[7:0] + 8'h01} :
        disp_addr + 14'h0001; // R14

    // blanking-mode update goes out once blank time arrives
    wire upd_go = trans & tblank & upd_pend &
        (h_blank | v_blank); // R19
    // interleave mode: update address owns the second bus phase
    wire upd_phase = trans & ~tblank & e_s; // R18

    // cursor window, blink and address match
    reg blink_on;
    always @* begin
        case (cmode)
            `CRTC_CUR_STEADY: blink_on = 1'b1;
            `CRTC_CUR_OFF: blink_on = 1'b0;
            `CRTC_CUR_FAST: blink_on = field_cnt[`CRTC_BLINK_FAST];
            `CRTC_CUR_SLOW: blink_on = field_cnt[`CRTC_BLINK_SLOW];
            default: blink_on = 1'b0;
        endcase
    end // R6
    wire cur_match = (disp_addr == cursor_addr) & blink_on &
        (scan_cnt >= cursor_start_line[4:0]) &
        (scan_cnt <= cursor_end_line) &
        h_display & v_active; // R8 R5
    wire de_now = h_display & v_active;

    // read data mux; status when select is low
    reg [7:0] next_rdata;
    always @* begin
        next_rdata = `CRTC_RST_ZERO8;
        if (!sel_s) begin
            next_rdata[`CRTC_ST_UPD] = upd_ready;
            next_rdata[`CRTC_ST_PEN] = pen_full;
            next_rdata[`CRTC_ST_VRT] = v_blank; // R17
        end else begin
            case (idx)
                `CRTC_IDX_CUR_HI:
                    next_rdata = {2'b00, cursor_addr[13:8]};
                `CRTC_IDX_CUR_LO:
                    next_rdata = cursor_addr[7:0];
                `CRTC_IDX_PEN_HI:
                    next_rdata = {2'b00, light_pen_addr[13:8]};
                `CRTC_IDX_PEN_LO:
                    next_rdata = light_pen_addr[7:0];
                default: next_rdata = `CRTC_RST_ZERO8; // R23
            endcase
        end
    end

    // pin synchronisers and edge history
    always @(posedge ref_clk) begin
        if (rst) begin
            // idle pin levels, so no false enable or pen edge follows
            pin_s1 <= `CRTC_PIN_IDLE;
            pin_s2 <= `CRTC_PIN_IDLE;
            din_s1 <= `CRTC_RST_ZERO8;
            din_s2 <= `CRTC_RST_ZERO8;
            e_d <= 1'b0;
            pen_d <= 1'b0;
        end else begin
            pin_s1 <= {chip_select_n, register_select, read_write,
                bus_enable, light_pen_input};
            pin_s2 <= pin_s1;
            din_s1 <= data_in;
            din_s2 <= din_s1;
            e_d <= e_s;
            pen_d <= pen_s;
        end
    end

    // bus driver: drives on every read except of the index 31 data register
    always @(posedge ref_clk) begin
        if (rst) begin
            data_out <= `CRTC_RST_ZERO8;
            data_oe_n <= 1'b1;
        end else begin
            data_out <= next_rdata;
            data_oe_n <= ~(~cs_s & rw_s & e_s &
                ~(sel_s & (idx == `CRTC_IDX_TRIG))); // R23
        end
    end

    // register writes
    always @(posedge ref_clk) begin
        if (rst) begin
            idx <= 5'h00;
            vert_total_adjust <= 5'h00;
            vert_displayed_rows <= 7'h00;
            vert_sync_row <= 7'h00;
            mode_control <= `CRTC_RST_ZERO8;
            scan_lines_per_row <= 5'h00;
            cursor_start_line <= 7'h00;
            cursor_end_line <= 5'h00;
            start_addr <= `CRTC_RST_ZERO14;
            cursor_addr <= `CRTC_RST_ZERO14;
        end else begin
            if (wr_idx)
                idx <= din_s2[4:0]; // R21
            if (wr) begin
                case (idx)
                    `CRTC_IDX_VADJ:
                        vert_total_adjust <= din_s2[4:0]; // R1
                    `CRTC_IDX_VDISP:
                        vert_displayed_rows <= din_s2[6:0]; // R2
                    `CRTC_IDX_VSYNC:
                        vert_sync_row <= din_s2[6:0]; // R3
                    `CRTC_IDX_MODE:
                        mode_control <= din_s2;
                    `CRTC_IDX_SCAN:
                        scan_lines_per_row <= din_s2[4:0]; // R4
                    `CRTC_IDX_CSTART:
                        cursor_start_line <= din_s2[6:0]; // R5
                    `CRTC_IDX_CEND:
                        cursor_end_line <= din_s2[4:0]; // R5
                    `CRTC_IDX_START_HI:
                        start_addr[13:8] <= din_s2[5:0]; // R7
                    `CRTC_IDX_START_LO:
                        start_addr[7:0] <= din_s2; // R7
                    `CRTC_IDX_CUR_HI:
                        cursor_addr[13:8] <= din_s2[5:0]; // R8
                    `CRTC_IDX_CUR_LO:
                        cursor_addr[7:0] <= din_s2; // R8
                    default: start_addr <= start_addr;
                endcase
            end
        end
    end

    // update address: load, then step once per update, wrapping
    always @(posedge ref_clk) begin
        if (rst) begin
            update_addr <= `CRTC_RST_ZERO14;
            upd_pend <= 1'b0;
            upd_ready <= 1'b0;
        end else begin
            if (wr && idx == `CRTC_IDX_UPD_HI)
                update_addr[13:8] <= din_s2[5:0]; // R11
            else if (wr && idx == `CRTC_IDX_UPD_LO)
                update_addr[7:0] <= din_s2; // R11
            else if ((trig & ~tblank) | upd_go)
                update_addr <= update_addr + 14'h0001; // R12 R24
            // a new trigger beats the retirement of the old one
            if (trig & trans & tblank)
                upd_pend <= 1'b1; // R19
            else if (upd_go)
                upd_pend <= 1'b0;
            // set beats the clear by an address load
            if ((trig & ~tblank) | upd_go)
                upd_ready <= 1'b1; // R13
            else if (wr && (idx == `CRTC_IDX_UPD_HI ||
                idx == `CRTC_IDX_UPD_LO))
                upd_ready <= 1'b0;
        end
    end

    // light pen capture on the character after the rising edge
    always @(posedge ref_clk) begin
        if (rst) begin
            light_pen_addr <= `CRTC_RST_ZERO14;
            pen_full <= 1'b0;
        end else begin
            if (pen_s & ~pen_d) begin
                light_pen_addr <= disp_addr; // R10
                pen_full <= 1'b1;
            end else if (rd && idx == `CRTC_IDX_PEN_LO) begin
                pen_full <= 1'b0;
            end
        end
    end

    // vertical row, scan and adjust counters
    always @(posedge ref_clk) begin
        if (rst) begin
            phase <= PH_ROWS;
            row_cnt <= 7'h00;
            scan_cnt <= 5'h00;
            adj_cnt <= 5'h00;
            field_cnt <= 5'h00;
        end else if (frame_end) begin
            phase <= PH_ROWS;
            row_cnt <= 7'h00;
            scan_cnt <= 5'h00;
            adj_cnt <= 5'h00;
            field_cnt <= field_cnt + 5'h01; // R6
        end else if (line_end) begin
            case (phase)
                PH_ROWS: begin
                    if (row_end) begin
                        scan_cnt <= 5'h00; // R4
                        if (last_row) begin
                            phase <= PH_ADJ; // R1
                            adj_cnt <= 5'h01;
                        end else begin
                            row_cnt <= row_cnt + 7'h01;
                        end
                    end else begin
                        scan_cnt <= scan_cnt + 5'h01;
                    end
                end
                PH_ADJ: begin
                    adj_cnt <= adj_cnt + 5'h01; // R1
                    scan_cnt <= scan_cnt + 5'h01;
                end
                default: phase <= PH_ROWS;
            endcase
        end
    end

    // vertical sync starts on the first line of the chosen row
    always @(posedge ref_clk) begin
        if (rst) begin
            vs_cnt <= 5'h00;
        end else if (line_end && phase == PH_ROWS && row_end &&
            !last_row && (row_cnt + 7'h01) == vert_sync_row) begin
            vs_cnt <= (vsync_width == 4'h0) ? `CRTC_VS_FULL :
                {1'b0, vsync_width}; // R3
        end else if (frame_end && vert_sync_row == 7'h00) begin
            vs_cnt <= (vsync_width == 4'h0) ? `CRTC_VS_FULL :
                {1'b0, vsync_width}; // R3
        end else if (line_end && vs_cnt != 5'h00) begin
            vs_cnt <= vs_cnt - 5'h01;
        end
    end

    // display address walk: frame reload beats line and char steps
    always @(posedge ref_clk) begin
        if (rst) begin
            disp_addr <= `CRTC_RST_ZERO14;
            row_base <= `CRTC_RST_ZERO14;
        end else if (frame_end) begin
            disp_addr <= start_addr; // R24 R7
            row_base <= start_addr;
        end else if (line_end) begin
            if (phase == PH_ROWS && row_end) begin
                disp_addr <= next_row_base;
                row_base <= next_row_base;
            end else begin
                disp_addr <= row_base;
            end
        end else if (h_display) begin
            disp_addr <= next_char; // R7
        end
    end

    // outputs; the skew flops trade one character of lag for
    // memories too slow to return data in the same character
    always @(posedge ref_clk) begin
        if (rst) begin
            memory_address_lines <= `CRTC_RST_ZERO14;
            row_scan_lines <= 5'h00;
            cur_hold <= 1'b0;
            de_hold <= 1'b0;
            cursor <= 1'b0;
            display_enable <= 1'b0;
            vsync <= 1'b0;
        end else begin
            if (upd_go | upd_phase)
                memory_address_lines <= update_addr; // R18 R19
            else
                memory_address_lines <= disp_addr;
            if (trans & mode_control[`CRTC_MODE_STROBE])
                row_scan_lines <= {upd_go, scan_cnt[3:0]}; // R22
            else
                row_scan_lines <= scan_cnt;
            cur_hold <= cur_match;
            de_hold <= de_now;
            cursor <= mode_control[`CRTC_MODE_CSKEW] ?
                cur_hold : cur_match; // R9
            display_enable <= mode_control[`CRTC_MODE_DSKEW] ?
                de_hold : de_now;
            vsync <= (vs_cnt != 5'h00);
        end
    end
endmodule

/* src/crtc_defs.vh */
// constants for the crt vertical timing, cursor and addressing block
// assumes a 5-bit register index and 14-bit display addresses
`ifndef CRTC_DEFS_VH
`define CRTC_DEFS_VH
// register indices
`define CRTC_IDX_VADJ 5'h05
`define CRTC_IDX_VDISP 5'h06
`define CRTC_IDX_VSYNC 5'h07
`define CRTC_IDX_MODE 5'h08
`define CRTC_IDX_SCAN 5'h09
`define CRTC_IDX_CSTART 5'h0a
`define CRTC_IDX_CEND 5'h0b
`define CRTC_IDX_START_HI 5'h0c
`define CRTC_IDX_START_LO 5'h0d
`define CRTC_IDX_CUR_HI 5'h0e
`define CRTC_IDX_CUR_LO 5'h0f
`define CRTC_IDX_PEN_HI 5'h10
`define CRTC_IDX_PEN_LO 5'h11
`define CRTC_IDX_UPD_HI 5'h12
`define CRTC_IDX_UPD_LO 5'h13
`define CRTC_IDX_TRIG 5'h1f
// mode control bit positions
`define CRTC_MODE_RC 2
`define CRTC_MODE_TRANS 3
`define CRTC_MODE_DSKEW 4
`define CRTC_MODE_CSKEW 5
`define CRTC_MODE_STROBE 6
`define CRTC_MODE_TBLANK 7
// cursor start field and cursor modes
`define CRTC_CMODE_HI 6
`define CRTC_CMODE_LO 5
`define CRTC_CUR_STEADY 2'b00
`define CRTC_CUR_OFF 2'b01
`define CRTC_CUR_FAST 2'b10
`define CRTC_CUR_SLOW 2'b11
// field counter bits for 16 and 32 field blink periods
`define CRTC_BLINK_FAST 3
`define CRTC_BLINK_SLOW 4
// status bit positions
`define CRTC_ST_UPD 7
`define CRTC_ST_PEN 6
`define CRTC_ST_VRT 5
// vsync width code zero means sixteen lines
`define CRTC_VS_FULL 5'h10
`define CRTC_RST_ZERO8 8'h00
`define CRTC_RST_ZERO14 14'h0000
// synchroniser idle: deselected, data select, read, enable and pen low
`define CRTC_PIN_IDLE 5'h1c
`endif

/* verif/crtc_hpartner.sv */
// line timing source in place of the horizontal block
// assumes one character per ref_clk edge, synchronous reset
module crtc_hpartner #(
    parameter int CHARS = 16, // characters per line
    parameter int SHOWN = 10 // displayed characters
) (
    input wire logic ref_clk, // character clock
    input wire logic rst, // reset, high
    output logic line_end, // last character
    output logic h_display, // display window
    output logic h_blank // blanking
);
    timeunit 1ns;
    timeprecision 1ps;
    int pos;
    // free running position; a short line keeps frames cheap
    always @(posedge ref_clk) begin
        if (rst || pos == CHARS - 1)
            pos <= 0;
        else
            pos <= pos + 1;
    end
    assign line_end = (pos == CHARS - 1);
    assign h_display = (pos < SHOWN);
    assign h_blank = !h_display;
endmodule

/* verif/crtc_vtiming_chk.sv */
// concurrent checks on the vertical timing block ports
// assumes a steady vsync_width while vsync runs
module crtc_vtiming_chk (
    input wire ref_clk, // clock
    input wire rst, // reset
    input wire chip_select_n, // select
    input wire read_write, // direction
    input wire bus_enable, // enable
    input wire data_oe_n, // drive
    input wire line_end, // line end
    input wire h_display, // window
    input wire h_blank, // blank
    input wire [3:0] vsync_width, // width
    input wire [4:0] row_scan_lines, // scan
    input wire display_enable, // display
    input wire cursor, // cursor
    input wire vsync // sync
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    int vs_lines;
    // lines seen inside vsync, judged as it falls
    always @(posedge ref_clk) begin
        if (rst || !vsync)
            vs_lines <= 0;
        else if (line_end)
            vs_lines <= vs_lines + 1;
    end
    chk_reset_idle: assert property ($fell(rst) |-> data_oe_n
        && !vsync && !cursor && !display_enable) else $error("busy");
    chk_desel_float: assert property (chip_select_n[*5] |-> data_oe_n)
        else $error("driven while deselected");
    chk_write_float: assert property (!read_write[*5] |-> data_oe_n)
        else $error("driven during write");
    chk_drive_cause: assert property (!data_oe_n |->
        $past(bus_enable, 2) || $past(bus_enable, 3) ||
        $past(bus_enable, 4) || $past(bus_enable, 5))
        else $error("driven without enable");
    chk_de_window: assert property (display_enable |->
        $past(h_display) || $past(h_display, 2)) else $error("de");
    chk_de_blank: assert property (h_blank[*3] |-> !display_enable)
        else $error("de in blank");
    // scan outputs are registered behind the counter: two edges of lag
    chk_scan_step: assert property (!$past(rst) &&
        $changed(row_scan_lines[3:0]) |-> $past(line_end, 2))
        else $error("scan moved mid line");
    chk_vsync_len: assert property ($fell(vsync) |-> vs_lines ==
        ((vsync_width == 4'h0) ? 16 : vsync_width)) else $error("vs");
    cov_vsync: cover property ($rose(vsync));
    cov_cursor: cover property ($rose(cursor));
    cov_read: cover property ($fell(data_oe_n));
    cov_strobe: cover property ($rose(row_scan_lines[4]));
endmodule
bind crtc_vtiming crtc_vtiming_chk crtc_vtiming_chk_i (
    .ref_clk(ref_clk), .rst(rst), .chip_select_n(chip_select_n),
    .read_write(read_write), .bus_enable(bus_enable),
    .data_oe_n(data_oe_n), .line_end(line_end), .h_display(h_display),
    .h_blank(h_blank), .vsync_width(vsync_width),
    .row_scan_lines(row_scan_lines), .display_enable(display_enable),
    .cursor(cursor), .vsync(vsync));

/* verif/crtc_vtiming_bench.sv */
// self-checking bench for the crt vertical timing block
// assumes the line partner: 16 chars, 10 shown
module crtc_vtiming_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] bus = 12'h800; // cs_n, select, rw, enable, data
    logic pen_in = 1'b0;
    logic [6:0] vtot = 7'h05;
    logic [3:0] vsw = 4'h3;
    wire le, hd, hb, oe_n, de_o, cur_o, vs_o;
    wire [7:0] dout;
    wire [13:0] mal;
    wire [4:0] rsl;
    int miscompares = 0;
    int num_checks = 0;
    int strobes = 0;
    int ln, de, cu;
    logic [13:0] strobe_addr;
    logic [7:0] q;
    logic oe;
    logic [13:0] addr_seen;
    int cur_exp [4] = '{64, 0, 32, 32};
    // scan 2 lines, 2 shown rows, sync row 3, adjust 1, cursor at 3
    logic [7:0] cfg [16] = '{8'h09, 8'h01, 8'h06, 8'h02, 8'h07, 8'h03,
        8'h05, 8'h01, 8'h0e, 8'h00, 8'h0f, 8'h03, 8'h0b, 8'h01,
        8'h08, 8'h00};
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    crtc_hpartner crtc_hpartner_i (.ref_clk(ref_clk), .rst(rst),
        .line_end(le), .h_display(hd), .h_blank(hb));
    crtc_vtiming crtc_vtiming_i (.ref_clk(ref_clk), .rst(rst),
        .chip_select_n(bus[11]), .register_select(bus[10]),
        .read_write(bus[9]), .bus_enable(bus[8]), .data_in(bus[7:0]),
        .data_out(dout), .data_oe_n(oe_n), .light_pen_input(pen_in),
        .line_end(le), .h_display(hd), .h_blank(hb), .vert_total(vtot),
        .vsync_width(vsw), .memory_address_lines(mal),
        .row_scan_lines(rsl), .display_enable(de_o), .cursor(cur_o),
        .vsync(vs_o));
    // shared-memory far side: outside logic gives the memory to the
    // device while enable is low and to the host while it is high
    wire [13:0] ram_addr = bus[8] ? 14'h2aaa : mal;
    // strobe watch at mid cycle, clear of the driving edge; it stands
    // for the hold latch that writes its held character on the strobe
    always @(negedge ref_clk) begin
        if (rsl[4]) begin
            strobes++;
            strobe_addr = mal;
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus cycle; enable held 8 edges, select held past its fall
    task automatic acc(input logic s, input logic r, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= {1'b0, s, r, 1'b1, d};
        repeat (7) @(posedge ref_clk);
        #1;
        q = dout;
        oe = oe_n;
        addr_seen = mal;
        @(posedge ref_clk);
        bus[8] <= 1'b0;
        repeat (5) @(posedge ref_clk);
        bus[11] <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        acc(1'b0, 1'b0, i);
        acc(1'b1, 1'b0, d);
    endtask
    task automatic rd(input logic [7:0] i);
        acc(1'b0, 1'b0, i);
        acc(1'b1, 1'b1, 8'h00);
    endtask
    // counts lines, display and cursor cycles over n whole frames
    task automatic meas(input int n);
        int f;
        logic pv;
        f = -1;
        pv = 1'b1;
        ln = 0;
        de = 0;
        cu = 0;
        while (f < n) begin
            @(posedge ref_clk);
            #1;
            if (vs_o && !pv)
                f++;
            pv = vs_o;
            if (f >= 0 && f < n) begin
                ln += le;
                de += de_o;
                cu += cur_o;
            end
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk);
        miscompares++;
        $display("ERROR t=%0t watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        chk(oe_n, 1'b1);
        for (int i = 0; i < 16; i += 2)
            wr(cfg[i], cfg[i + 1]);
        wr(8'h0e, 8'hff);
        rd(8'h0e);
        chk(q, 8'h3f);
        wr(8'h0e, 8'h00);
        rd(8'h0f);
        chk(q, 8'h03);
        rd(8'h1a);
        chk(q, 8'h00);
        rd(8'h1f);
        chk(oe, 1'b1);
        $display("register test done");
        for (int m = 0; m < 4; m++) begin
            wr(8'h0a, 8'(m << 5));
            meas(32);
            chk(ln, 32 * 13);
            chk(de, 32 * 40);
            chk(cu, cur_exp[m]);
        end
        wr(8'h0a, 8'h00);
        wr(8'h0b, 8'h00);
        meas(1);
        chk(cu, 1);
        // meas stops as vsync rises, so the host reads inside retrace
        acc(1'b0, 1'b1, 8'h00);
        chk(q[5], 1'b1);
        chk(ram_addr, mal);
        $display("frame test done");
        wr(8'h08, 8'h08);
        wr(8'h12, 8'h3f);
        wr(8'h13, 8'hff);
        wr(8'h1f, 8'h00);
        chk(addr_seen, 14'h3fff);
        acc(1'b0, 1'b1, 8'h00);
        chk({q[7], q[6], q[4:0]}, 7'h40);
        chk(addr_seen, 14'h0000);
        wr(8'h08, 8'hc8);
        wr(8'h12, 8'h00);
        wr(8'h13, 8'h40);
        strobes = 0;
        wr(8'h1f, 8'h00);
        repeat (40) @(posedge ref_clk);
        chk(strobes, 1);
        chk(strobe_addr, 14'h0040);
        acc(1'b0, 1'b1, 8'h00);
        chk(q[7], 1'b1);
        wr(8'h08, 8'h00);
        pen_in <= 1'b1;
        repeat (10) @(posedge ref_clk);
        acc(1'b0, 1'b1, 8'h00);
        chk(q[6], 1'b1);
        rd(8'h11);
        acc(1'b0, 1'b1, 8'h00);
        chk(q[6], 1'b0);
        $display("update and light pen test done");
        tally_and_finish();
    end
endmodule
